// ===== dv/sube_file_model.sv
// Purpose: data register file beside the subtract block
// Assumes: read data due one cycle after file_rd_en
// Notes:   outside a read the data toggle so stale bytes never match
`timescale 1ns/100ps
`default_nettype none

module sube_file_model (
  input  wire logic        clk,
  input  wire logic        file_rd_en,
  input  wire logic [11:0] file_addr,
  input  wire logic        file_wr_en,
  input  wire logic [7:0]  file_wr_data,
  output logic      [7:0]  file_rd_data
);
  logic [7:0] mem [0:4095];

  // every location readable, so no unknown reaches the flags
  initial begin
    file_rd_data = 8'h00;
    for (int i = 0; i < 4096; i++) begin
      mem[i] = 8'(i);
    end
  end

  always @(posedge clk) begin
    if (file_wr_en) begin
      mem[file_addr] <= file_wr_data;
    end
    if (file_rd_en) begin
      file_rd_data <= mem[file_addr];
    end else begin
      file_rd_data <= ~file_rd_data;
    end
  end
endmodule

`default_nettype wire

// ===== dv/tb.sv
// Purpose: self-checking bench for the subtract execution block
// Assumes: bench acts as decoder, model acts as register file
// Notes:   expected values from a bench-side reference subtract
`timescale 1ns/100ps
`default_nettype none
`include "sube_defs.svh"

module tb;
  logic        clk = 1'b0, reset_n = 1'b0, ce = 1'b1, instr_valid = 1'b0;
  logic [15:0] instr_word = 16'h0000;
  logic [7:0]  acc = 8'h00, reg_wdata = 8'h00, file_rd_data, acc_wr_data;
  logic        carry_in = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0]  bank_pointer = 4'h0;
  logic [11:0] index_base = 12'h000, file_addr;
  logic [1:0]  reg_addr = 2'h0;
  logic        busy, file_rd_en, file_wr_en, acc_wr_en, flags_wr_en, done;
  logic        c_flag, nibble_carry_flag, z_flag, signed_range_flag, n_flag;
  logic [7:0]  file_wr_data, reg_rdata, rv;
  int          num_errors = 0, total_checks = 0;

  always #2.5 clk = ~clk;

  sube_exec dut (.clk(clk), .reset_n(reset_n), .ce(ce),
    .instr_valid(instr_valid), .instr_word(instr_word), .acc(acc),
    .carry_in(carry_in), .bank_pointer(bank_pointer),
    .index_base(index_base), .file_rd_data(file_rd_data),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .busy(busy), .file_rd_en(file_rd_en),
    .file_addr(file_addr), .file_wr_en(file_wr_en),
    .file_wr_data(file_wr_data), .acc_wr_en(acc_wr_en),
    .acc_wr_data(acc_wr_data), .flags_wr_en(flags_wr_en), .c_flag(c_flag),
    .nibble_carry_flag(nibble_carry_flag), .z_flag(z_flag),
    .signed_range_flag(signed_range_flag), .n_flag(n_flag), .done(done),
    .reg_rdata(reg_rdata));

  sube_file_model u_file (.clk(clk), .file_rd_en(file_rd_en),
    .file_addr(file_addr), .file_wr_en(file_wr_en),
    .file_wr_data(file_wr_data), .file_rd_data(file_rd_data));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [11:0] got, input logic [11:0] exp,
                     input string msg);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // returns {n, ov, z, dc, c, diff}
  function automatic logic [12:0] ref_sub(input logic [7:0] a,
      input logic [7:0] b, input logic cin);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'b0, a} + {1'b0, ~b} + 9'(cin);
    h = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'(cin);
    return {s[7], (a[7] != b[7]) && (s[7] != a[7]), s[7:0] == 8'h00,
            h[4], s[8], s[7:0]};
  endfunction

  task automatic exec(input logic [15:0] word, input logic [7:0] w,
                      input logic c, input int lat);
    int n;
    n = 1;
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_word  <= word;
    acc         <= w;
    carry_in    <= c;
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
    chk({11'h0, busy}, 12'h001, "busy after take");
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (done !== 1'b1 && n < 8);
    chk(12'(n), 12'(lat), "latency");
    chk({11'h0, busy}, 12'h000, "busy at done");
  endtask

  task automatic chk_flags(input logic [12:0] e);
    chk({11'h0, flags_wr_en}, 12'h001, "flags strobe");
    chk(12'({n_flag, signed_range_flag, z_flag, nibble_carry_flag, c_flag}),
        12'(e[12:8]), "flags");
  endtask

  task automatic reg_access(input logic wr, input logic [1:0] a,
                            input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= wr;
    reg_rd    <= ~wr;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
    rv = reg_rdata;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_literal();
    logic [7:0]  k [5] = '{8'h02, 8'h02, 8'h02, 8'h7f, 8'h10};
    logic [7:0]  w [5] = '{8'h01, 8'h02, 8'h03, 8'hff, 8'h01};
    logic [8:0]  r [5] = '{9'h101, 9'h100, 9'h0ff, 9'h080, 9'h10f};
    logic [12:0] e;
    for (int i = 0; i < 5; i++) begin
      exec({`SUBE_OPC_LW, k[i]}, w[i], 1'b0, 2);
      e = ref_sub(k[i], w[i], 1'b1);
      chk({11'h0, acc_wr_en}, 12'h001, "lit acc strobe");
      chk({4'h0, acc_wr_data}, {4'h0, e[7:0]}, "lit diff");
      chk({3'h0, c_flag, acc_wr_data}, {3'h0, r[i]}, "lit fixed");
      chk_flags(e);
    end
    // unmatched word, then a literal held while ce is low
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_word  <= 16'h0908;
    @(posedge clk);
    ce          <= 1'b0;
    instr_word  <= {`SUBE_OPC_LW, 8'h05};
    repeat (3) @(posedge clk);
    #1;
    chk({11'h0, busy | done}, 12'h000, "ignored offers");
    @(posedge clk);
    instr_valid <= 1'b0;
    ce          <= 1'b1;
    $display("test literal done");
  endtask

  task automatic t_borrow();
    logic        d [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    logic [7:0]  f [5] = '{8'h03, 8'h02, 8'h01, 8'h01, 8'h0f};
    logic [7:0]  w [5] = '{8'h02, 8'h05, 8'h02, 8'h80, 8'h10};
    logic        c [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    logic [8:0]  r [5] = '{9'h0ff, 9'h103, 9'h100, 9'h17f, 9'h100};
    logic [12:0] e;
    for (int i = 0; i < 5; i++) begin
      u_file.mem[12'hf80 + i] = f[i];
      exec({`SUBE_OPC_FWB, d[i], 1'b0, 8'h80 + 8'(i)}, w[i], c[i], 3);
      e = ref_sub(w[i], f[i], c[i]);
      chk(file_addr, 12'hf80 + 12'(i), "access bank high");
      chk({11'h0, file_wr_en}, {11'h0, d[i]}, "file strobe");
      chk({11'h0, acc_wr_en}, {11'h0, ~d[i]}, "acc strobe");
      chk({4'h0, d[i] ? file_wr_data : acc_wr_data},
          {4'h0, e[7:0]}, "borrow diff");
      chk({3'h0, c_flag, d[i] ? file_wr_data : acc_wr_data},
          {3'h0, r[i]}, "borrow fixed");
      chk_flags(e);
    end
    $display("test borrow done");
  endtask

  task automatic t_address();
    logic        x [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
    logic        a [6] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
    logic [7:0]  f [6] = '{8'h12, 8'h12, 8'h5f, 8'h60, 8'h10, 8'h30};
    logic [11:0] b [6] = '{12'h200, 12'h200, 12'h200, 12'h200, 12'h200,
                           12'hfe0};
    logic [11:0] e [6] = '{12'h512, 12'h012, 12'h25f, 12'hf60, 12'h510,
                           12'h010};
    for (int i = 0; i < 6; i++) begin
      reg_access(1'b1, `SUBE_REG_CFG, {7'h00, x[i]});
      @(posedge clk);
      bank_pointer <= 4'h5;
      index_base   <= b[i];
      exec({`SUBE_OPC_FWB, 1'b0, a[i], f[i]}, 8'h00, 1'b1, 3);
      chk(file_addr, e[i], "operand address");
    end
    $display("test address done");
  endtask

  task automatic t_regs();
    logic [12:0] e;
    reg_access(1'b0, `SUBE_REG_CFG, 8'h00);
    chk({4'h0, rv}, 12'h001, "config readback");
    u_file.mem[12'h5f0] = 8'h01;
    exec({`SUBE_OPC_FWB, 1'b0, 1'b1, 8'hf0}, 8'h80, 1'b1, 3);
    e = ref_sub(8'h80, 8'h01, 1'b1);
    reg_access(1'b1, `SUBE_REG_STAT, 8'hff);
    reg_access(1'b0, `SUBE_REG_STAT, 8'h00);
    chk({4'h0, rv}, {7'h00, e[12:8]}, "status reg");
    reg_access(1'b0, `SUBE_REG_RES, 8'h00);
    chk({4'h0, rv}, {4'h0, e[7:0]}, "result reg");
    @(posedge clk);
    #1;
    chk({4'h0, reg_rdata}, 12'h000, "read data drops");
    reg_access(1'b0, 2'h3, 8'h00);
    chk({4'h0, rv}, 12'h000, "unmapped read");
    $display("test registers done");
  endtask

  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    reg_access(1'b0, `SUBE_REG_CFG, 8'h00);
    chk({4'h0, rv}, 12'h000, "config reset");
    t_literal();
    t_borrow();
    t_address();
    t_regs();
    wrap_up();
  end

  // whole run is about a hundred cycles
  initial begin
    #20000;
    num_errors++;
    wrap_up();
  end
endmodule

`default_nettype wire

// ===== include/sube_defs.svh
// Purpose: constants for the subtract execution block
// Assumes: 16-bit instruction word, 8-bit data, 12-bit data address
// Notes:   definitions only
`ifndef SUBE_DEFS_SVH
`define SUBE_DEFS_SVH

// ----------------------------------------
// instruction encoding
// ----------------------------------------
`define SUBE_OPC_FWB      6'h15
`define SUBE_OPC_LW       8'h08
`define SUBE_FWB_HI       15
`define SUBE_FWB_LO       10
`define SUBE_LW_HI        15
`define SUBE_LW_LO        8
`define SUBE_DEST_BIT     9
`define SUBE_WIN_BIT      8

// ----------------------------------------
// addressing
// ----------------------------------------
`define SUBE_ILO_MAX      8'h5f
`define SUBE_ACC_SPLIT    8'h60
`define SUBE_ACC_LO_BANK  4'h0
`define SUBE_ACC_HI_BANK  4'hf

// ----------------------------------------
// register port map and fields
// ----------------------------------------
`define SUBE_REG_CFG      2'h0
`define SUBE_REG_STAT     2'h1
`define SUBE_REG_RES      2'h2
`define SUBE_CFG_EXT      0
`define SUBE_ST_C         0
`define SUBE_ST_DC        1
`define SUBE_ST_Z         2
`define SUBE_ST_OV        3
`define SUBE_ST_N         4
`define SUBE_CFG_RST      1'h0
`define SUBE_BYTE_ZERO    8'h00
`define SUBE_ADDR_ZERO    12'h000

`endif

// ===== include/sube_pkg.sv
// Purpose: types for the subtract execution block
// Assumes: nothing
// Notes:   constants live in sube_defs.svh
package sube_pkg;

  // ----------------------------------------
  // sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    SUBE_IDLE  = 3'b001,
    SUBE_FETCH = 3'b010,
    SUBE_EXEC  = 3'b100
  } sube_state_e;

endpackage

// ===== rtl/sube_alu.sv
// Purpose: 8-bit subtract with carry-as-not-borrow and flags
// Assumes: carry_in high means no borrow pending
// Notes:   purely combinational
`timescale 1ns/100ps
`default_nettype none

module sube_alu (
  input  wire logic [7:0] minuend,
  input  wire logic [7:0] subtrahend,
  input  wire logic       carry_in,
  output logic      [7:0] diff,
  output logic            c_out,
  output logic            dc_out,
  output logic            ov_out,
  output logic            z_out,
  output logic            n_out
);

  logic [8:0] full_sum;
  logic [4:0] low_sum;

  // ----------------------------------------
  // two's complement datapath
  // ----------------------------------------
  // RULE1 add inverted operand
  always_comb begin
    full_sum = {1'b0, minuend} + {1'b0, ~subtrahend} + {8'h00, carry_in};
    low_sum  = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]}
             + {4'h0, carry_in};
    diff     = full_sum[7:0];
    // RULE8 carry set means no borrow
    c_out    = full_sum[8];
    // RULE3 flag derivation
    dc_out   = low_sum[4];
    ov_out   = (minuend[7] != subtrahend[7]) && (diff[7] != minuend[7]);
    z_out    = (diff == 8'h00);
    n_out    = diff[7];
  end

endmodule

`default_nettype wire

// ===== rtl/sube_exec.sv
// Purpose: executes the two subtract instructions of the core
// Assumes: decoder, register file and accumulator share clk
// Notes:   file read data arrives one cycle after file_rd_en
//
// How it works
// RULE1 - with-borrow form computes accumulator minus operand minus inverted carry
// RULE2 - with-borrow opcode is 0101 01, then dest bit, window bit, address
// RULE3 - with-borrow updates negative, signed range, carry, nibble, zero flags
// RULE4 - dest bit 0 writes accumulator, 1 writes back the operand location
// RULE5 - window bit 0 uses fixed access bank, 1 uses bank_pointer
// RULE6 - window 0, extended set on, address up to 95: indexed literal offset
// RULE7 - opcode 0000 1000 computes immediate minus accumulator into accumulator
// RULE8 - carry cleared on borrow, set otherwise
`timescale 1ns/100ps
`default_nettype none
`include "sube_defs.svh"

module sube_exec (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        ce,
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr_word,
  input  wire logic [7:0]  acc,
  input  wire logic        carry_in,
  input  wire logic [3:0]  bank_pointer,
  input  wire logic [11:0] index_base,
  input  wire logic [7:0]  file_rd_data,
  input  wire logic [1:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic             busy,
  output logic             file_rd_en,
  output logic      [11:0] file_addr,
  output logic             file_wr_en,
  output logic      [7:0]  file_wr_data,
  output logic             acc_wr_en,
  output logic      [7:0]  acc_wr_data,
  output logic             flags_wr_en,
  output logic             c_flag,
  output logic             nibble_carry_flag,
  output logic             z_flag,
  output logic             signed_range_flag,
  output logic             n_flag,
  output logic             done,
  output logic      [7:0]  reg_rdata
);
  sube_pkg::sube_state_e state, next_state;
  logic        is_lit, dest_file, ext_enable;
  logic [7:0]  imm, last_result;
  logic        next_is_lit, next_dest_file, next_ext_enable;
  logic [7:0]  next_imm, next_last_result;
  logic        next_busy, next_file_rd_en, next_file_wr_en;
  logic [11:0] next_file_addr;
  logic [7:0]  next_file_wr_data, next_acc_wr_data, next_reg_rdata;
  logic        next_acc_wr_en, next_flags_wr_en, next_done;
  logic        next_c, next_dc, next_z, next_ov, next_n;
  logic        dec_fwb, dec_lw;
  logic [7:0]  dec_f, alu_a, alu_b, alu_diff;
  logic        alu_cin, alu_c, alu_dc, alu_ov, alu_z, alu_n;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  always_comb begin
    // RULE2 with-borrow opcode match
    dec_fwb = (instr_word[`SUBE_FWB_HI:`SUBE_FWB_LO] == `SUBE_OPC_FWB);
    // RULE7 literal opcode match
    dec_lw  = (instr_word[`SUBE_LW_HI:`SUBE_LW_LO] == `SUBE_OPC_LW);
    dec_f   = instr_word[7:0];
  end

  // ----------------------------------------
  // arithmetic
  // ----------------------------------------
  // operands: literal form is k - acc with no borrow in
  always_comb begin
    // RULE7 immediate minus accumulator
    alu_a   = is_lit ? imm : acc;
    alu_b   = is_lit ? acc : file_rd_data;
    // RULE1 inverted carry is the borrow
    alu_cin = is_lit ? 1'b1 : carry_in;
  end

  sube_alu u_alu (
    .minuend    (alu_a),
    .subtrahend (alu_b),
    .carry_in   (alu_cin),
    .diff       (alu_diff),
    .c_out      (alu_c),
    .dc_out     (alu_dc),
    .ov_out     (alu_ov),
    .z_out      (alu_z),
    .n_out      (alu_n)
  );

  // ----------------------------------------
  // sequencer and outputs
  // ----------------------------------------
  always_comb begin
    next_state        = state;
    next_is_lit       = is_lit;
    next_dest_file    = dest_file;
    next_imm          = imm;
    next_ext_enable   = ext_enable;
    next_last_result  = last_result;
    next_file_addr    = file_addr;
    next_file_wr_data = file_wr_data;
    next_acc_wr_data  = acc_wr_data;
    next_c            = c_flag;
    next_dc           = nibble_carry_flag;
    next_z            = z_flag;
    next_ov           = signed_range_flag;
    next_n            = n_flag;
    next_file_rd_en   = 1'b0;
    next_file_wr_en   = 1'b0;
    next_acc_wr_en    = 1'b0;
    next_flags_wr_en  = 1'b0;
    next_done         = 1'b0;
    next_reg_rdata    = `SUBE_BYTE_ZERO;
    case (state)
      sube_pkg::SUBE_IDLE: begin
        if (instr_valid && dec_lw) begin
          next_is_lit = 1'b1;
          next_imm    = dec_f;
          next_state  = sube_pkg::SUBE_EXEC;
        end else if (instr_valid && dec_fwb) begin
          next_is_lit     = 1'b0;
          next_dest_file  = instr_word[`SUBE_DEST_BIT];
          next_file_rd_en = 1'b1;
          next_state      = sube_pkg::SUBE_FETCH;
          // RULE6 indexed literal offset
          if (!instr_word[`SUBE_WIN_BIT] && ext_enable &&
              dec_f <= `SUBE_ILO_MAX) begin
            next_file_addr = index_base + {4'h0, dec_f};
          // RULE5 bank_pointer window
          end else if (instr_word[`SUBE_WIN_BIT]) begin
            next_file_addr = {bank_pointer, dec_f};
          // RULE5 fixed access bank
          end else if (dec_f < `SUBE_ACC_SPLIT) begin
            next_file_addr = {`SUBE_ACC_LO_BANK, dec_f};
          end else begin
            next_file_addr = {`SUBE_ACC_HI_BANK, dec_f};
          end
        end
      end
      // read data lands in the cycle after the strobe
      sube_pkg::SUBE_FETCH: begin
        next_state = sube_pkg::SUBE_EXEC;
      end
      sube_pkg::SUBE_EXEC: begin
        next_state       = sube_pkg::SUBE_IDLE;
        next_done        = 1'b1;
        next_last_result = alu_diff;
        // RULE3 all five flags update
        next_flags_wr_en = 1'b1;
        // RULE8 carry from adder
        next_c           = alu_c;
        next_dc          = alu_dc;
        next_z           = alu_z;
        next_ov          = alu_ov;
        next_n           = alu_n;
        // RULE4 destination select
        if (!is_lit && dest_file) begin
          next_file_wr_en   = 1'b1;
          next_file_wr_data = alu_diff;
        end else begin
          next_acc_wr_en   = 1'b1;
          next_acc_wr_data = alu_diff;
        end
      end
      default: begin
        next_state = sube_pkg::SUBE_IDLE;
      end
    endcase
    next_busy = (next_state != sube_pkg::SUBE_IDLE);
    // config write steers indexed addressing
    if (reg_wr && reg_addr == `SUBE_REG_CFG) begin
      next_ext_enable = reg_wdata[`SUBE_CFG_EXT];
    end
    if (reg_rd) begin
      case (reg_addr)
        `SUBE_REG_CFG:  next_reg_rdata = {7'h00, ext_enable};
        `SUBE_REG_STAT: next_reg_rdata = {3'h0, n_flag, signed_range_flag,
                                          z_flag, nibble_carry_flag, c_flag};
        `SUBE_REG_RES:  next_reg_rdata = last_result;
        default:        next_reg_rdata = `SUBE_BYTE_ZERO;
      endcase
    end
  end

  // ce low freezes everything, including the read answer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state             <= sube_pkg::SUBE_IDLE;
      is_lit            <= 1'b0;
      dest_file         <= 1'b0;
      imm               <= `SUBE_BYTE_ZERO;
      ext_enable        <= `SUBE_CFG_RST;
      last_result       <= `SUBE_BYTE_ZERO;
      busy              <= 1'b0;
      file_rd_en        <= 1'b0;
      file_addr         <= `SUBE_ADDR_ZERO;
      file_wr_en        <= 1'b0;
      file_wr_data      <= `SUBE_BYTE_ZERO;
      acc_wr_en         <= 1'b0;
      acc_wr_data       <= `SUBE_BYTE_ZERO;
      flags_wr_en       <= 1'b0;
      c_flag            <= 1'b0;
      nibble_carry_flag <= 1'b0;
      z_flag            <= 1'b0;
      signed_range_flag <= 1'b0;
      n_flag            <= 1'b0;
      done              <= 1'b0;
      reg_rdata         <= `SUBE_BYTE_ZERO;
    end else if (ce) begin
      state             <= next_state;
      is_lit            <= next_is_lit;
      dest_file         <= next_dest_file;
      imm               <= next_imm;
      ext_enable        <= next_ext_enable;
      last_result       <= next_last_result;
      busy              <= next_busy;
      file_rd_en        <= next_file_rd_en;
      file_addr         <= next_file_addr;
      file_wr_en        <= next_file_wr_en;
      file_wr_data      <= next_file_wr_data;
      acc_wr_en         <= next_acc_wr_en;
      acc_wr_data       <= next_acc_wr_data;
      flags_wr_en       <= next_flags_wr_en;
      c_flag            <= next_c;
      nibble_carry_flag <= next_dc;
      z_flag            <= next_z;
      signed_range_flag <= next_ov;
      n_flag            <= next_n;
      done              <= next_done;
      reg_rdata         <= next_reg_rdata;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // RULE1 result matches borrow equation
  a_fwb_result: assert property (@(posedge clk) disable iff (!reset_n)
    (ce && state == sube_pkg::SUBE_EXEC && !is_lit) |=>
    (last_result == 8'($past(acc) - $past(file_rd_data)
                       - {7'h00, !$past(carry_in)})))
    else $error("with-borrow difference wrong");

  // RULE2 with-borrow take issues a read
  a_fwb_read: assert property (@(posedge clk) disable iff (!reset_n)
    (ce && state == sube_pkg::SUBE_IDLE && instr_valid && dec_fwb && !dec_lw)
    |=> (file_rd_en && busy) ##1 !file_rd_en)
    else $error("operand read not issued");

  // RULE3 zero and negative flags follow result
  a_flag_set: assert property (@(posedge clk) disable iff (!reset_n)
    flags_wr_en |-> (z_flag == (last_result == 8'h00)) &&
                    (n_flag == last_result[7]))
    else $error("zero or negative flag wrong");

  // RULE4 one destination per instruction
  a_dest_one: assert property (@(posedge clk) disable iff (!reset_n)
    done |-> (file_wr_en != acc_wr_en) &&
             (file_wr_en == (dest_file && !is_lit)) &&
             !(is_lit && file_wr_en))
    else $error("destination select wrong");

  // RULE5 bank_pointer window
  a_bank_win: assert property (@(posedge clk) disable iff (!reset_n)
    (ce && state == sube_pkg::SUBE_IDLE && instr_valid && dec_fwb &&
     instr_word[`SUBE_WIN_BIT]) |=>
    (file_addr == {$past(bank_pointer), $past(dec_f)}))
    else $error("banked address wrong");

  // RULE6 indexed literal offset
  a_ilo_addr: assert property (@(posedge clk) disable iff (!reset_n)
    (ce && state == sube_pkg::SUBE_IDLE && instr_valid && dec_fwb &&
     !instr_word[`SUBE_WIN_BIT] && ext_enable && dec_f <= `SUBE_ILO_MAX) |=>
    (file_addr == $past(index_base) + {4'h0, $past(dec_f)}))
    else $error("indexed address wrong");

  // RULE7 literal result in two cycles
  a_lit_result: assert property (@(posedge clk) disable iff (!reset_n)
    (ce && state == sube_pkg::SUBE_IDLE && instr_valid && dec_lw) ##1 ce
    |=> (acc_wr_en && done &&
         acc_wr_data == 8'($past(instr_word[7:0], 2) - $past(acc))))
    else $error("literal result wrong");

  // RULE8 literal form: carry low exactly on borrow
  a_borrow_c: assert property (@(posedge clk) disable iff (!reset_n)
    (ce && state == sube_pkg::SUBE_EXEC && is_lit) |=>
    (c_flag == ($past(imm) >= $past(acc))))
    else $error("carry polarity wrong");
endmodule

`default_nettype wire
